// file: core/level_query_command_handler.sv
// Command interpreter for the protection and authentication level queries
`timescale 1ns/1ps
module level_query_command_handler #(
  parameter logic [7:0] STS_PACKET   = lvq_pkg::STS_PACKET,
  parameter logic [7:0] STS_CHECKSUM = lvq_pkg::STS_CHECKSUM,
  parameter logic [7:0] STS_ACCEPT   = lvq_pkg::STS_ACCEPT
) (
  // Clock and reset
  input  wire logic       I_CLOCK,
  input  wire logic       I_RST_B,
  // Received bytes
  input  wire logic       I_RX_VALID,
  input  wire logic [7:0] I_RX_DATA,
  output logic            O_RX_READY,
  // Transmitted bytes
  output logic            O_TX_VALID,
  output logic      [7:0] O_TX_DATA,
  input  wire logic       I_TX_READY,
  // Device state
  input  wire logic [7:0] I_PROT_LEVEL,
  input  wire logic [7:0] I_AUTH_LEVEL,
  input  wire logic       I_ENC_WRITE_DONE,
  // Status
  output logic            O_BUSY
);
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_LENH  = 3'b001,
    S_LENL  = 3'b010,
    S_BODY  = 3'b011,
    S_SUM   = 3'b100,
    S_TERM  = 3'b101,
    S_REPLY = 3'b110
  } state_type;

  state_type   state_q;
  state_type   state_d;
  logic [7:0]  length_high_byte_q;
  logic [7:0]  length_low_byte_q;
  logic [15:0] len_cnt_q;
  logic [7:0]  cmd_q;
  logic [7:0]  sum_q;
  logic [7:0]  rx_sum_q;
  logic        enc_lock_q;
  logic [3:0]  idx_q;
  logic [3:0]  last_idx_q;
  logic        is_err_q;
  logic [7:0]  response_code_byte_q;
  logic [7:0]  status_code_byte_q;
  logic [7:0]  level_q;

  wire        rx_take   = I_RX_VALID && O_RX_READY;
  wire [15:0] rx_len    = {length_high_byte_q, length_low_byte_q};
  wire        cmd_prot  = (cmd_q == lvq_pkg::CMD_PROT_Q);
  wire        term_ok   = (I_RX_DATA == lvq_pkg::TERM_BYTE);
  // Header byte counts in neither sum
  wire        sum_ok    = (8'(sum_q + rx_sum_q) == 8'h00);
  wire        fmt_ok    = (rx_len != 16'h0000) && (rx_len <= lvq_pkg::MAX_LEN);
  wire        cmd_len_ok = (length_high_byte_q == lvq_pkg::LEN_HI_ZERO) &&
                           (length_low_byte_q == lvq_pkg::LEN_QUERY);
  // Unknown command codes are dropped silently: no reply code exists for them
  wire        cmd_known = cmd_prot || (cmd_q == lvq_pkg::CMD_AUTH_Q);
  wire [7:0]  sts_sel   = !term_ok    ? STS_PACKET :
                          !sum_ok     ? STS_CHECKSUM :
                          !fmt_ok     ? STS_PACKET :
                          !cmd_len_ok ? STS_PACKET :
                          enc_lock_q  ? STS_ACCEPT :
                                        8'h00;
  wire        pkt_err   = (sts_sel != 8'h00);
  wire        fifo_ready;
  wire        tx_push   = (state_q == S_REPLY);
  wire        tx_adv    = tx_push && fifo_ready;

  // Reply byte select; payload sum precomputed into the checksum slot
  logic [7:0] tx_byte;
  logic [7:0] tx_sum;
  wire  [7:0] w_ff      = lvq_pkg::UNUSED_WORD[7:0];
  always_comb begin
    tx_sum = is_err_q ? 8'(lvq_pkg::LEN_ERR_REPLY + response_code_byte_q + status_code_byte_q +
                           lvq_pkg::UNUSED_WORD[31:24] + w_ff + w_ff + w_ff +
                           lvq_pkg::UNUSED_WORD[31:24] + w_ff + w_ff + w_ff)
                      : 8'(lvq_pkg::LEN_OK_REPLY + response_code_byte_q + level_q);
    tx_sum = 8'(8'h00 - tx_sum);
    tx_byte = 8'h00;
    unique case (idx_q)
      4'h0:    tx_byte = lvq_pkg::HDR_DATA;
      4'h1:    tx_byte = lvq_pkg::LEN_HI_ZERO;
      4'h2:    tx_byte = is_err_q ? lvq_pkg::LEN_ERR_REPLY : lvq_pkg::LEN_OK_REPLY;
      4'h3:    tx_byte = response_code_byte_q;
      4'h4:    tx_byte = is_err_q ? status_code_byte_q : level_q;
      4'h5:    tx_byte = is_err_q ? lvq_pkg::UNUSED_WORD[31:24] : tx_sum;
      4'h6:    tx_byte = is_err_q ? w_ff : lvq_pkg::TERM_BYTE;
      4'h9:    tx_byte = lvq_pkg::UNUSED_WORD[31:24];
      4'hD:    tx_byte = tx_sum;
      4'hE:    tx_byte = lvq_pkg::TERM_BYTE;
      default: tx_byte = w_ff;
    endcase
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE:  if (rx_take && I_RX_DATA == lvq_pkg::HDR_CMD) state_d = S_LENH;
      S_LENH:  if (rx_take) state_d = S_LENL;
      S_LENL:  if (rx_take) state_d = S_BODY;
      S_BODY:  if (rx_take && len_cnt_q == 16'h0001) state_d = S_SUM;
      S_SUM:   if (rx_take) state_d = S_TERM;
      S_TERM:  if (rx_take) state_d = cmd_known ? S_REPLY : S_IDLE;
      S_REPLY: if (tx_adv && idx_q == last_idx_q) state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  assign O_RX_READY = (state_q != S_REPLY);
  assign O_BUSY     = (state_q != S_IDLE);

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Lock holds until the next device reset
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      enc_lock_q <= 1'b0;
    end else if (I_ENC_WRITE_DONE) begin
      enc_lock_q <= 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      length_high_byte_q <= 8'h00;
      length_low_byte_q  <= 8'h00;
      len_cnt_q          <= 16'h0000;
      cmd_q              <= 8'h00;
      sum_q              <= 8'h00;
      rx_sum_q           <= 8'h00;
    end else if (rx_take) begin
      unique case (state_q)
        S_LENH: begin
          length_high_byte_q <= I_RX_DATA;
          sum_q              <= I_RX_DATA;
        end
        S_LENL: begin
          length_low_byte_q <= I_RX_DATA;
          len_cnt_q         <= (I_RX_DATA == 8'h00 && length_high_byte_q == 8'h00) ? 16'h0001
                               : {length_high_byte_q, I_RX_DATA};
          sum_q             <= 8'(sum_q + I_RX_DATA);
        end
        S_BODY: begin
          if (len_cnt_q == rx_len || rx_len == 16'h0000) begin
            cmd_q <= I_RX_DATA;
          end
          len_cnt_q <= 16'(len_cnt_q - 16'h0001);
          sum_q     <= 8'(sum_q + I_RX_DATA);
        end
        S_SUM:   rx_sum_q <= I_RX_DATA;
        default: ;
      endcase
    end
  end

  // Reply set up at the terminator slot; errors replace the level reply
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      idx_q                <= 4'h0;
      last_idx_q           <= 4'h6;
      is_err_q             <= 1'b0;
      response_code_byte_q <= 8'h00;
      status_code_byte_q   <= 8'h00;
      level_q              <= 8'h00;
    end else if (state_q == S_TERM && rx_take) begin
      idx_q                <= 4'h0;
      is_err_q             <= pkt_err;
      last_idx_q           <= pkt_err ? 4'hE : 4'h6;
      status_code_byte_q   <= sts_sel;
      response_code_byte_q <= pkt_err ? (cmd_prot ? lvq_pkg::ERR_PROT_Q : lvq_pkg::ERR_AUTH_Q)
                                      : cmd_q;
      level_q              <= cmd_prot ? I_PROT_LEVEL : I_AUTH_LEVEL;
    end else if (tx_adv) begin
      idx_q <= 4'(idx_q + 4'h1);
    end
  end

  lvq_fifo #(
    .WIDTH (lvq_pkg::FIFO_WIDTH),
    .DEPTH (lvq_pkg::FIFO_DEPTH)
  ) u_txq (
    .i_clk   (I_CLOCK),
    .i_rst_b (I_RST_B),
    .i_valid (tx_push),
    .i_data  (tx_byte),
    .o_ready (fifo_ready),
    .o_valid (O_TX_VALID),
    .o_data  (O_TX_DATA),
    .i_ready (I_TX_READY)
  );

  property p_hdr_first;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
      (state_q == S_TERM && rx_take) |=> (idx_q == 4'h0) && (tx_byte == lvq_pkg::HDR_DATA);
  endproperty
  a_hdr_first: assert property (p_hdr_first) else $error("reply does not start with data header");

  property p_wait_hdr;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
      (state_q == S_IDLE && rx_take && I_RX_DATA != lvq_pkg::HDR_CMD) |=> (state_q == S_IDLE);
  endproperty
  a_wait_hdr: assert property (p_wait_hdr) else $error("non header byte left idle");

  property p_lock_err;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
      (state_q == S_TERM && rx_take && enc_lock_q) |=> is_err_q;
  endproperty
  a_lock_err: assert property (p_lock_err) else $error("query accepted while locked");

  property p_err_len;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
      (state_q == S_REPLY && is_err_q && idx_q == 4'h2) |-> (tx_byte == lvq_pkg::LEN_ERR_REPLY);
  endproperty
  a_err_len: assert property (p_err_len) else $error("error reply length wrong");

  property p_term_prio;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
      (state_q == S_TERM && rx_take && !term_ok && cmd_known) |=> (status_code_byte_q == STS_PACKET) && is_err_q;
  endproperty
  a_term_prio: assert property (p_term_prio) else $error("missing terminator not reported first");

  property p_back_idle;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
      (tx_adv && idx_q == last_idx_q) |=> (state_q == S_IDLE);
  endproperty
  a_back_idle: assert property (p_back_idle) else $error("no return to command wait");
endmodule // level_query_command_handler

// file: core/lvq_pkg.sv
// Package with packet constants, status codes and reply layout for the level query handler
//
// Behaviour
// - Received bytes are ignored until a header byte 01h arrives, which starts a command packet.
// - A good protection level query is answered by 81h 00h 02h 73h, the level code, checksum and 03h.
// - A good authentication level query is answered by 81h 00h 02h 75h, the level code, checksum and 03h.
// - A failed protection level query is answered with length 00h/0Ah, code F3h, status, four detail and four address bytes.
// - A failed authentication level query is answered the same way with code F5h.
// - A packet without its terminator byte is answered with a packet error status.
// - A checksum byte that disagrees with the computed one is answered with a checksum error status.
// - Length bytes that break the general format or the command's own length give a packet error status.
// - After any error no command action is taken and the block waits for a new command.
// - Queries are refused with an acceptance error while no reset has followed an encrypted data write.
// - Errors are reported in the order terminator, checksum, format length, command length, acceptance, with detail and address FFFFFFFh.
// - A good protection level query reports the current level and changes nothing.
// - A good authentication level query reports the current level and changes nothing.
package lvq_pkg;
  localparam logic [7:0]  HDR_CMD       = 8'h01;
  localparam logic [7:0]  HDR_DATA      = 8'h81;
  localparam logic [7:0]  TERM_BYTE     = 8'h03;
  localparam logic [7:0]  CMD_PROT_Q    = 8'h73;
  localparam logic [7:0]  CMD_AUTH_Q    = 8'h75;
  localparam logic [7:0]  ERR_PROT_Q    = 8'hF3;
  localparam logic [7:0]  ERR_AUTH_Q    = 8'hF5;
  localparam logic [7:0]  LEN_HI_ZERO   = 8'h00;
  localparam logic [7:0]  LEN_QUERY     = 8'h01;
  localparam logic [7:0]  LEN_OK_REPLY  = 8'h02;
  localparam logic [7:0]  LEN_ERR_REPLY = 8'h0A;
  localparam logic [31:0] UNUSED_WORD   = 32'h0FFFFFFF;
  localparam logic [15:0] MAX_LEN       = 16'h0100;
  localparam logic [7:0]  STS_PACKET    = 8'hC1;
  localparam logic [7:0]  STS_CHECKSUM  = 8'hC2;
  localparam logic [7:0]  STS_ACCEPT    = 8'hC3;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          FIFO_WIDTH    = 8;
endpackage

// file: core/lvq_fifo.sv
// Byte FIFO between the reply builder and the serial transmitter
`timescale 1ns/1ps
module lvq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  // Fill side
  input  wire logic             i_valid,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_ready,
  // Drain side
  output logic                  o_valid,
  output logic      [WIDTH-1:0] o_data,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  wire              full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire              empty = (wp_q == rp_q);
  wire              push  = i_valid && !full;
  wire              pop   = i_ready && !empty;
  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data  = mem[rp_q[AW-1:0]];
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= i_data;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_q + (AW+1)'(push);
      rp_q <= rp_q + (AW+1)'(pop);
    end
  end
endmodule // lvq_fifo

// file: test/lvq_host_model.sv
// Host tool model: sends command bytes and drains reply bytes with stalls
`timescale 1ns/1ps
module lvq_host_model (
  // Clock
  input  wire logic       i_clk,
  // Command stream
  output logic            o_rx_valid,
  output logic      [7:0] o_rx_data,
  input  wire logic       i_rx_ready,
  // Reply stream
  input  wire logic       i_stall,
  output logic            o_tx_ready
);
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h5A;
  end
  // A stalled host withholds ready, so replies back up in the FIFO
  assign o_tx_ready = ~i_stall;
  ////////////////////////////////////////////////////////////////
  // Ready is looked at mid-cycle where it is settled; the byte is taken at the next edge
  task automatic send(input logic [7:0] p[$]);
    logic ok;
    foreach (p[i]) begin
      o_rx_valid = 1'b1;
      o_rx_data  = p[i];
      do begin
        @(negedge i_clk);
        ok = i_rx_ready;
        @(posedge i_clk);
      end while (ok !== 1'b1);
      #1;
    end
    o_rx_valid = 1'b0;
    // A released line must not keep showing the last byte
    o_rx_data  = ~o_rx_data;
  endtask
endmodule // lvq_host_model

// file: test/level_query_command_handler_bench.sv
// Self-checking bench for the level query command handler
`timescale 1ns/1ps
module level_query_command_handler_bench;
  // Non-default codes show that the parameters reach the replies
  localparam logic [7:0] STS_P = 8'hD1;
  localparam logic [7:0] STS_C = 8'hD2;
  localparam logic [7:0] STS_A = 8'hD3;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        rx_valid;
  logic  [7:0] rx_data;
  logic        rx_ready;
  logic        tx_valid;
  logic  [7:0] tx_data;
  logic        tx_ready;
  logic  [7:0] prot = 8'h02;
  logic  [7:0] auth = 8'h02;
  logic        enc = 1'b0;
  logic        busy;
  logic        stall = 1'b0;
  logic        hold = 1'b0;
  logic [31:0] lfsr_q = 32'h6D9C26EA;
  logic  [7:0] exp_q[$];
  logic  [7:0] want;
  logic  [7:0] long_pkt[$];
  int          miscompares = 0;
  int          n_tests = 0;
  int          cyc = 0;

  level_query_command_handler #(.STS_PACKET(STS_P), .STS_CHECKSUM(STS_C), .STS_ACCEPT(STS_A))
    u_level_query_command_handler (
    .I_CLOCK(clk), .I_RST_B(rst_b), .I_RX_VALID(rx_valid), .I_RX_DATA(rx_data), .O_RX_READY(rx_ready),
    .O_TX_VALID(tx_valid), .O_TX_DATA(tx_data), .I_TX_READY(tx_ready), .I_PROT_LEVEL(prot),
    .I_AUTH_LEVEL(auth), .I_ENC_WRITE_DONE(enc), .O_BUSY(busy));
  lvq_host_model u_lvq_host_model (.i_clk(clk), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .i_rx_ready(rx_ready), .i_stall(stall), .o_tx_ready(tx_ready));
  ////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;

  function automatic logic [31:0] lfsr_next();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction

  always @(posedge clk) begin
    #1 stall <= hold | (lfsr_next() > 32'h80000000);
  end

  task automatic test_done();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////
  // Each popped reply byte is matched against the oldest note; a byte nobody expected meets X
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      want = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hXX;
      n_tests++;
      if (tx_data !== want) begin
        $display("ERROR %0t: got %h expected %h", $time, tx_data, want);
        miscompares++;
      end
    end
  end

  task automatic note(input logic [7:0] b[$]);
    logic [7:0] s;
    s = 8'h00;
    exp_q.push_back(8'h81);
    foreach (b[i]) begin
      exp_q.push_back(b[i]);
      s = s - b[i];
    end
    exp_q.push_back(s);
    exp_q.push_back(8'h03);
  endtask

  task automatic ok(input logic [7:0] res, input logic [7:0] lvl);
    note('{8'h00, 8'h02, res, lvl});
  endtask

  task automatic err(input logic [7:0] res, input logic [7:0] sts);
    note('{8'h00, 8'h0A, res, sts, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF});
  endtask

  // Busy and receive ready against the contract, looked at off the clock edge
  task automatic chk(input logic [1:0] w);
    n_tests++;
    if ({busy, rx_ready} !== w) begin
      $display("ERROR %0t: got %h expected %h", $time, {busy, rx_ready}, w);
      miscompares++;
    end
  endtask

  task automatic run(input logic [7:0] p[$]);
    int n;
    u_lvq_host_model.send(p);
    // Last terminator was taken at the edge just passed, so the reply is being built
    chk(2'b10);
    n = 0;
    while ((exp_q.size() != 0 || busy !== 1'b0) && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n == 400) begin
      $display("ERROR %0t: reply left %h expected %h", $time, exp_q.size(), 0);
      miscompares++;
    end
    repeat (4) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    #1 chk(2'b01);
    rst_b = 1'b1;
    for (int k = 0; k < 3; k++) begin
      prot = 8'h02 + 8'(k);
      auth = 8'h02 + 8'(lfsr_next() % 32'd3);
      ok(8'h73, prot);
      ok(8'h75, auth);
      run('{8'h00, 8'h81, 8'h03, 8'h01, 8'h00, 8'h01, 8'h73, 8'h8C, 8'h03,
            8'h01, 8'h00, 8'h01, 8'h75, 8'h8A, 8'h03});
    end
    err(8'hF3, STS_P);
    run('{8'h01, 8'h00, 8'h01, 8'h73, 8'h8C, 8'h00});
    err(8'hF5, STS_C);
    run('{8'h01, 8'h00, 8'h01, 8'h75, 8'h8B, 8'h03});
    err(8'hF5, STS_P);
    run('{8'h01, 8'h00, 8'h01, 8'h75, 8'h8B, 8'h00});
    err(8'hF3, STS_P);
    run('{8'h01, 8'h00, 8'h00, 8'h73, 8'h8D, 8'h03});
    err(8'hF3, STS_P);
    run('{8'h01, 8'h00, 8'h02, 8'h73, 8'h00, 8'h8B, 8'h03});
    // One byte past the longest legal body: format length is the first check to fail, ahead of command length
    long_pkt = '{8'h01, 8'h01, 8'h01, 8'h73};
    repeat (256) long_pkt.push_back(8'h00);
    long_pkt.push_back(8'h8B);
    long_pkt.push_back(8'h03);
    err(8'hF3, STS_P);
    run(long_pkt);
    err(8'hF5, STS_C);
    run('{8'h01, 8'h00, 8'h02, 8'h75, 8'h00, 8'h00, 8'h03});
    ok(8'h73, prot);
    run('{8'h01, 8'h00, 8'h01, 8'h70, 8'h8F, 8'h03, 8'h01, 8'h00, 8'h01, 8'h73, 8'h8C, 8'h03});
    enc = 1'b1;
    @(posedge clk);
    #1 enc = 1'b0;
    // Host stalls hard so the second reply fills the FIFO before draining
    hold = 1'b1;
    fork
      begin
        repeat (100) @(posedge clk);
        hold = 1'b0;
      end
    join_none
    err(8'hF3, STS_A);
    err(8'hF5, STS_A);
    run('{8'h01, 8'h00, 8'h01, 8'h73, 8'h8C, 8'h03, 8'h01, 8'h00, 8'h01, 8'h75, 8'h8A, 8'h03});
    err(8'hF3, STS_P);
    run('{8'h01, 8'h00, 8'h02, 8'h73, 8'h00, 8'h8B, 8'h03});
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(2'b01);
    rst_b = 1'b1;
    ok(8'h75, auth);
    run('{8'h01, 8'h00, 8'h01, 8'h75, 8'h8A, 8'h03});
    test_done();
  end
endmodule // level_query_command_handler_bench
